// >>> rtl/xcvr_mode_pkg.sv
// Shared constants, types and state layouts for the dual transceiver mode logic
package xcvr_mode_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and timebase
   localparam int CLK_MHZ  = 200;                       // Core clock rate
   localparam int TICK_NS  = 50;                        // Timebase tick period
   localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;  // Cycles per tick
   localparam int TICK_CW  = 4;                         // Tick divider width
   localparam int CW       = 16;                        // Width of all tick counters
   localparam int NCH      = 2;                         // Channel count

   ////////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses) and fields
   localparam logic [11:0] CTRL_OFF    = 12'h000;       // Control register
   localparam logic [11:0] STATUS_OFF  = 12'h004;       // Status register
   localparam int          CTRL_LATCH  = 0;             // Latching receive variant
   localparam int          CTRL_IOSUP  = 1;             // I/O supplied variant
   localparam logic        LATCH_RST   = 1'b0;          // Reset of latching select
   localparam logic        IOSUP_RST   = 1'b1;          // Reset of I/O supplied select
   localparam int          ST_STRIDE   = 8;             // Status bits per channel
   localparam int          ST_MODE     = 0;             // Mode field, 2 bits
   localparam int          ST_WOKEN    = 2;             // Wake-up detected
   localparam int          ST_TOUT     = 3;             // Dominant timeout tripped
   localparam int          ST_OTBLK    = 4;             // Drivers blocked by heat

   ////////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {MODE_OFF, MODE_STANDBY, MODE_NORMAL} mode_t;
   typedef enum logic [2:0] {WK_IDLE, WK_DOM1, WK_REC, WK_DOM2, WK_DONE} wake_t;

   ////////////////////////////////////////////////////////////////////////////////
   // State layouts
   typedef struct packed {
      logic          stb_f;     // Filtered standby select
      logic [CW-1:0] stb_cnt;   // Standby select filter count
      mode_t         mode;      // Current mode
      logic          tx_armed;  // High level seen in Normal mode
      logic [CW-1:0] to_cnt;    // Dominant timeout count
      logic          to_trip;   // Transmitter disabled by timeout
      logic          ot_block;  // Drivers disabled by overtemperature
      logic          lp_bus;    // Filtered low-power receiver, 1 = dominant
      logic [CW-1:0] lp_cnt;    // Low-power filter count
      wake_t         wst;       // Wake pattern phase
      logic [CW-1:0] ph_cnt;    // Phase duration count
      logic [CW-1:0] win_cnt;   // Pattern window count
      logic          woken;     // Wake-up event raised
      logic [CW-1:0] su_cnt;    // Receive startup count
      logic          su_done;   // Receive startup elapsed
      logic          rxd;       // Registered receive output
      logic          rx_oe;     // Receive output enable
      logic          drv;       // Drive bus dominant
      logic          bias;      // Bus biased to ground
      logic          hiz;       // Bus high impedance
   } chan_t;

   typedef struct packed {
      logic [TICK_CW-1:0] tick_cnt;   // Timebase divider
      logic               tick;       // Timebase enable pulse
      logic               stbuv_f;    // Filtered standby undervoltage
      logic [CW-1:0]      stbuv_cnt;  // Its filter count
      logic               swoff_f;    // Filtered switch-off undervoltage
      logic [CW-1:0]      swoff_cnt;  // Its filter count
      logic               latch_var;  // Latching receive variant
      logic               io_var;     // I/O supplied variant
      logic [31:0]        prdata;     // Registered read data
      chan_t [NCH-1:0]    ch;         // Per channel state
   } top_t;
endpackage

// >>> rtl/xcvr_mode_wake.sv
// Mode, wake-up and protection logic for both transceiver channels
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
module xcvr_mode_wake
   import xcvr_mode_pkg::*;
#(
   parameter int WAKE_DOM_NS   = 1000,     // Least dominant wake phase
   parameter int WAKE_REC_NS   = 1000,     // Least recessive wake phase
   parameter int WAKE_WIN_NS   = 1000000,  // Longest pattern window
   parameter int FLTR_WAKE_NS  = 500,      // Low-power receiver filter
   parameter int STARTUP_RX_NS = 25000,    // Receive startup delay
   parameter int TO_DOM_NS     = 1000000,  // Dominant timeout
   parameter int FLTR_IO_NS    = 500,      // Standby select filter
   parameter int UV_DET_NS     = 10000,    // Standby undervoltage detect
   parameter int SWOFF_DET_NS  = 10000     // Switch-off undervoltage detect
) (
   input  wire logic           core_clk_i,            // Core clock
   input  wire logic           reset_i,               // Synchronous reset
   // APB slave
   input  wire logic           psel_i,                // Select
   input  wire logic           penable_i,             // Access phase
   input  wire logic           pwrite_i,              // Write
   input  wire logic [11:0]    paddr_i,               // Byte address
   input  wire logic [31:0]    pwdata_i,              // Write data
   output logic      [31:0]    prdata_o,              // Read data
   output logic                pready_o,              // Ready
   output logic                pslverr_o,             // Error on unmapped
   // Shared supply and temperature flags
   input  wire logic           vcc_stb_uv_i,          // Main below standby level
   input  wire logic           vcc_swoff_uv_i,        // Main below switch-off
   input  wire logic           io_swoff_uv_i,         // I/O below switch-off
   input  wire logic           overtemp_i,            // Above shutdown level
   input  wire logic           temp_released_i,       // Below release level
   // Per channel controller side
   input  wire logic [NCH-1:0] transmit_input_i,      // Transmit level
   input  wire logic [NCH-1:0] transmit_driven_i,     // Transmit pin is driven
   input  wire logic [NCH-1:0] standby_select_i,      // Standby select level
   input  wire logic [NCH-1:0] standby_driven_i,      // Select pin is driven
   output logic      [NCH-1:0] receive_output_o,      // Receive level
   output logic      [NCH-1:0] receive_output_oe_o,   // Receive enable
   // Per channel bus side
   input  wire logic [NCH-1:0] bus_dominant_i,        // Receiver sees dominant
   output logic      [NCH-1:0] bus_drive_dominant_o,  // Drive dominant
   output logic      [NCH-1:0] bus_bias_gnd_o,        // Bias lines to ground
   output logic      [NCH-1:0] bus_hiz_o              // Lines high impedance
);

   ////////////////////////////////////////////////////////////////////////////////
   // Tick counts, least times round up, longest times round down
   // Minimum times are never shortened by the tick grid,
   // the window limit is never lengthened by it, the timeout trips on tick TO_TK + 1
   localparam logic [TICK_CW-1:0] TICK_LAST = TICK_CW'(TICK_CYC - 1);  // Divider end
   localparam logic [CW-1:0] DOM_TK = CW'((WAKE_DOM_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [CW-1:0] REC_TK = CW'((WAKE_REC_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [CW-1:0] WIN_TK = CW'(WAKE_WIN_NS / TICK_NS);
   localparam logic [CW-1:0] FLT_TK = CW'((FLTR_WAKE_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [CW-1:0] SU_TK  = CW'((STARTUP_RX_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [CW-1:0] TO_TK  = CW'(TO_DOM_NS / TICK_NS);
   localparam logic [CW-1:0] IO_TK  = CW'((FLTR_IO_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [CW-1:0] UV_TK  = CW'((UV_DET_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [CW-1:0] OFF_TK = CW'((SWOFF_DET_NS + TICK_NS - 1) / TICK_NS);

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   // Level filter: output takes a new level after it held for lim ticks
   // Packed result: new level on top, count below
   // Count restarts whenever raw matches the output
   function automatic logic [CW:0] filter_step(input logic          cur,
                                               input logic [CW-1:0] cnt,
                                               input logic          raw,
                                               input logic          tk,
                                               input logic [CW-1:0] lim);
      logic [CW:0] r;
      r = {cur, cnt};
      if (raw == cur) begin
         r = {cur, {CW{1'b0}}};
      end else if (tk) begin
         if (cnt + 1'b1 >= lim) begin
            r = {raw, {CW{1'b0}}};
         end else begin
            r = {cur, cnt + 1'b1};
         end
      end
      return r;
   endfunction

   // Mode from detectors and select, off wins, then standby
   // Fixed priority leaves no detector mix undefined
   function automatic mode_t resolve(input logic off_uv,
                                     input logic stb_uv,
                                     input logic sel);
      mode_t m;
      if (off_uv) begin
         m = MODE_OFF;
      end else if (stb_uv || sel) begin
         m = MODE_STANDBY;
      end else begin
         m = MODE_NORMAL;
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State
   top_t s;      // Registered state
   top_t nxt_s;  // Next state

   // Next state logic
   always_comb begin
      chan_t       c;      // Working channel copy
      logic [CW:0] f;      // Filter result
      logic        txd;    // Effective transmit level
      logic        sel;    // Raw select with pull-up
      logic        off_r;  // Governing switch-off flag
      logic        lvl;    // Level wanted by wake phase
      logic        lp;     // Filtered bus, 1 = dominant
      logic [CW-1:0] lim;  // Phase length wanted
      logic [31:0] stat;   // Status word
      // Defaults keep every path assigned
      nxt_s = s;
      c     = s.ch[0];
      f     = '0;
      txd   = 1'b1;
      sel   = 1'b1;
      lvl   = 1'b0;
      lp    = 1'b0;
      lim   = DOM_TK;
      stat  = 32'h0000_0000;

      // Timebase pulse
      // One pulse per tick drives every duration count
      nxt_s.tick     = (s.tick_cnt == TICK_LAST);
      nxt_s.tick_cnt = nxt_s.tick ? '0 : s.tick_cnt + 1'b1;

      // Shared supply detectors
      // Symmetric filters: recovery takes as long as entry
      // The variant bit picks the supply that governs Off
      f = filter_step(s.stbuv_f, s.stbuv_cnt, vcc_stb_uv_i, s.tick, UV_TK);
      {nxt_s.stbuv_f, nxt_s.stbuv_cnt} = f;
      off_r = s.io_var ? io_swoff_uv_i : vcc_swoff_uv_i;
      f = filter_step(s.swoff_f, s.swoff_cnt, off_r, s.tick, OFF_TK);
      {nxt_s.swoff_f, nxt_s.swoff_cnt} = f;

      // Independent channels
      // Channels share only the timebase, supply filters, heat flags and variant bits
      for (int i = 0; i < NCH; i++) begin
         c   = s.ch[i];
         txd = !transmit_driven_i[i] || transmit_input_i[i];
         sel = !standby_driven_i[i] || standby_select_i[i];
         f   = filter_step(s.ch[i].stb_f, s.ch[i].stb_cnt, sel, s.tick, IO_TK);
         c.stb_f   = f[CW];
         c.stb_cnt = f[CW-1:0];
         c.mode    = resolve(s.swoff_f, s.stbuv_f, s.ch[i].stb_f);

         // Low-power receiver filter
         // Short pulses never reach the wake detector
         f = filter_step(s.ch[i].lp_bus, s.ch[i].lp_cnt, bus_dominant_i[i],
                         s.tick, FLT_TK);
         c.lp_bus = f[CW];
         c.lp_cnt = f[CW-1:0];
         lp       = s.ch[i].lp_bus;

         // Wake pattern detector
         // Leaving Standby, or low main supply with Normal asked,
         // clears the pattern and any pending wake
         if (s.ch[i].mode != MODE_STANDBY || (s.stbuv_f && !s.ch[i].stb_f)) begin
            c.wst     = WK_IDLE;
            c.woken   = 1'b0;
            c.su_cnt  = '0;
            c.su_done = 1'b0;
         end else begin
            lvl = (s.ch[i].wst == WK_REC) ? !lp : lp;
            lim = (s.ch[i].wst == WK_REC) ? REC_TK : DOM_TK;
            unique case (s.ch[i].wst)
               WK_IDLE: begin
                  // First dominant opens the window
                  if (lp) begin
                     c.wst     = WK_DOM1;
                     c.ph_cnt  = '0;
                     c.win_cnt = '0;
                  end
               end
               WK_DOM1, WK_REC, WK_DOM2: begin
                  // Phases advance only on ticks
                  // A wrong level restarts only the phase count,
                  // the window runs on from the first dominant
                  if (!s.tick) begin
                     c.wst = s.ch[i].wst;
                  end else if (s.ch[i].win_cnt + 1'b1 >= WIN_TK) begin
                     c.wst = WK_IDLE;
                  end else begin
                     c.win_cnt = s.ch[i].win_cnt + 1'b1;
                     if (!lvl) begin
                        c.ph_cnt = '0;
                     end else if (s.ch[i].ph_cnt + 1'b1 >= lim) begin
                        c.ph_cnt = '0;
                        if (s.ch[i].wst == WK_DOM1) begin
                           c.wst = WK_REC;
                        end else if (s.ch[i].wst == WK_REC) begin
                           c.wst = WK_DOM2;
                        end else begin
                           c.wst   = WK_DONE;
                           c.woken = 1'b1;
                        end
                     end else begin
                        c.ph_cnt = s.ch[i].ph_cnt + 1'b1;
                     end
                  end
               end
               WK_DONE: begin
                  // Receive startup delay runs
                  if (s.tick && !s.ch[i].su_done) begin
                     c.su_cnt  = s.ch[i].su_cnt + 1'b1;
                     c.su_done = (s.ch[i].su_cnt + 1'b1 >= SU_TK);
                  end
               end
            endcase
         end

         // Dominant timeout and first high arming
         // Trip holds until transmit goes high again
         if (s.ch[i].mode != MODE_NORMAL) begin
            c.tx_armed = 1'b0;
            c.to_cnt   = '0;
            c.to_trip  = 1'b0;
         end else if (txd) begin
            c.tx_armed = 1'b1;
            c.to_cnt   = '0;
            c.to_trip  = 1'b0;
         end else if (s.tick && !s.ch[i].to_trip) begin
            if (s.ch[i].to_cnt >= TO_TK) begin
               c.to_trip = 1'b1;
            end else begin
               c.to_cnt = s.ch[i].to_cnt + 1'b1;
            end
         end

         // Overtemperature block, released only on high transmit in Normal
         // Waiting for a high level stops drivers toggling
         // across the temperature hysteresis
         if (overtemp_i) begin
            c.ot_block = 1'b1;
         end else if (temp_released_i && txd && s.ch[i].mode == MODE_NORMAL) begin
            c.ot_block = 1'b0;
         end

         // Output levels
         // Outputs are registered one cycle behind the mode
         c.drv   = (s.ch[i].mode == MODE_NORMAL) && !txd && s.ch[i].tx_armed &&
                   !s.ch[i].to_trip && !s.ch[i].ot_block;
         c.bias  = (s.ch[i].mode == MODE_STANDBY);
         c.hiz   = (s.ch[i].mode == MODE_OFF);
         c.rx_oe = (s.ch[i].mode != MODE_OFF);
         unique case (s.ch[i].mode)
            MODE_OFF: begin
               c.rxd = 1'b1;
            end
            MODE_NORMAL: begin
               c.rxd = !bus_dominant_i[i];
            end
            MODE_STANDBY: begin
               if (s.stbuv_f && !s.ch[i].stb_f) begin
                  c.rxd = !lp;
               end else if (s.ch[i].woken && s.ch[i].su_done) begin
                  c.rxd = s.latch_var ? 1'b0 : !lp;
               end else begin
                  c.rxd = 1'b1;
               end
            end
         endcase
         nxt_s.ch[i] = c;

         // Status fields
         // Status shows the registered channel state
         stat[i*ST_STRIDE + ST_MODE +: 2] = s.ch[i].mode;
         stat[i*ST_STRIDE + ST_WOKEN]     = s.ch[i].woken;
         stat[i*ST_STRIDE + ST_TOUT]      = s.ch[i].to_trip;
         stat[i*ST_STRIDE + ST_OTBLK]     = s.ch[i].ot_block;
      end

      // APB write on access phase
      // Writes to Status are dropped, other addresses are refused by the error flag
      if (psel_i && penable_i && pwrite_i && paddr_i[11:2] == CTRL_OFF[11:2]) begin
         nxt_s.latch_var = pwdata_i[CTRL_LATCH];
         nxt_s.io_var    = pwdata_i[CTRL_IOSUP];
      end

      // APB read data captured in setup
      // Capture in setup lets the access phase end at once
      if (psel_i && !penable_i) begin
         if (paddr_i[11:2] == CTRL_OFF[11:2]) begin
            nxt_s.prdata = 32'h0000_0000;
            nxt_s.prdata[CTRL_LATCH] = s.latch_var;
            nxt_s.prdata[CTRL_IOSUP] = s.io_var;
         end else if (paddr_i[11:2] == STATUS_OFF[11:2]) begin
            nxt_s.prdata = stat;
         end else begin
            nxt_s.prdata = 32'h0000_0000;
         end
      end
   end

   // State register
   // Reset enters Off with the switch-off filter set, so
   // outputs stay released until the supply flag clears
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s           <= '0;
         s.latch_var <= LATCH_RST;
         s.io_var    <= IOSUP_RST;
         s.swoff_f   <= 1'b1;
         for (int i = 0; i < NCH; i++) begin
            s.ch[i].stb_f <= 1'b1;
            s.ch[i].mode  <= MODE_OFF;
            s.ch[i].rxd   <= 1'b1;
            s.ch[i].hiz   <= 1'b1;
         end
      end else begin
         s <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata_o  = s.prdata;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && (paddr_i[11:2] != CTRL_OFF[11:2]) &&
                      (paddr_i[11:2] != STATUS_OFF[11:2]);

   // Per channel output unpacking
   // Every pin comes straight from a state flip-flop
   generate
      for (genvar g = 0; g < NCH; g++) begin : g_out
         assign receive_output_o[g]     = s.ch[g].rxd;
         assign receive_output_oe_o[g]  = s.ch[g].rx_oe;
         assign bus_drive_dominant_o[g] = s.ch[g].drv;
         assign bus_bias_gnd_o[g]       = s.ch[g].bias;
         assign bus_hiz_o[g]            = s.ch[g].hiz;
      end
   endgenerate

endmodule

// >>> test/can_host_model.sv
// Controller stand-in driving the select and transmit pins
`timescale 1ns/10ps
module can_host_model (
   input  wire logic       core_clk_i,
   input  wire logic [1:0] want_normal_i,
   input  wire logic [1:0] tx_low_i,
   input  wire logic [1:0] tx_float_i,
   output logic      [1:0] standby_select_o,
   output logic      [1:0] standby_driven_o,
   output logic      [1:0] transmit_input_o,
   output logic      [1:0] transmit_driven_o
);
   // Pins move just after the edge; select pin is released for Standby
   always_ff @(posedge core_clk_i) begin
      standby_select_o  <= ~want_normal_i;
      standby_driven_o  <= want_normal_i;
      transmit_input_o  <= ~tx_low_i;
      transmit_driven_o <= ~tx_float_i;
   end
endmodule

// >>> test/xcvr_mode_wake_asserts.sv
// Port checker for the transceiver mode logic
`timescale 1ns/10ps
module xcvr_mode_wake_asserts
   import xcvr_mode_pkg::*;
#(
   parameter int TO_DOM_NS    = 1000000,
   parameter int SWOFF_DET_NS = 10000
) (
   input wire logic           core_clk_i,
   input wire logic           reset_i,
   input wire logic           psel_i,
   input wire logic           penable_i,
   input wire logic [11:0]    paddr_i,
   input wire logic           pready_o,
   input wire logic           pslverr_o,
   input wire logic           io_swoff_uv_i,
   input wire logic           overtemp_i,
   input wire logic [NCH-1:0] transmit_input_i,
   input wire logic [NCH-1:0] transmit_driven_i,
   input wire logic [NCH-1:0] bus_dominant_i,
   input wire logic [NCH-1:0] receive_output_o,
   input wire logic [NCH-1:0] receive_output_oe_o,
   input wire logic [NCH-1:0] bus_drive_dominant_o,
   input wire logic [NCH-1:0] bus_bias_gnd_o,
   input wire logic [NCH-1:0] bus_hiz_o
);
   localparam int TO_LIM = TO_DOM_NS / 5 + 30;     // Timeout in cycles plus slack
   localparam int SW_LIM = SWOFF_DET_NS / 5 + 30;  // Switch-off filter plus slack
   logic        tx_lo;  // Channel 0 transmit held low
   logic        nrm;    // Channel 0 in Normal
   logic [11:0] lo_ff;  // Cycles of low transmit in Normal
   logic [11:0] uv_ff;  // Cycles of I/O switch-off flag
   assign tx_lo = transmit_driven_i[0] & ~transmit_input_i[0];
   assign nrm   = ~bus_hiz_o[0] & ~bus_bias_gnd_o[0];
   ////////////////////////////////////////////////////////////////////////////////
   // Saturating duration counters
   always_ff @(posedge core_clk_i) begin
      lo_ff <= (reset_i || !(nrm && tx_lo)) ? 12'h000 : lo_ff + {11'h000, lo_ff != 12'hFFF};
      uv_ff <= (reset_i || !io_swoff_uv_i) ? 12'h000 : uv_ff + {11'h000, uv_ff != 12'hFFF};
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////////////
   property p_slverr;
      psel_i && penable_i && paddr_i[11:2] > 10'h001 |-> pslverr_o && pready_o;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_hiz;
      bus_hiz_o[0] |-> !bus_drive_dominant_o[0] && !receive_output_oe_o[0] && !bus_bias_gnd_o[0];
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs active in Off");
   property p_bias;
      bus_bias_gnd_o[0] |-> !bus_drive_dominant_o[0];
   endproperty
   a_bias: assert property (p_bias) else $error("driving in Standby");
   property p_drive;
      bus_drive_dominant_o[0] |-> $past(tx_lo) || $past(tx_lo, 2);
   endproperty
   a_drive: assert property (p_drive) else $error("dominant without low transmit");
   property p_tout;
      lo_ff >= TO_LIM |-> !bus_drive_dominant_o[0];
   endproperty
   a_tout: assert property (p_tout) else $error("dominant timeout missed");
   property p_swoff;
      uv_ff >= SW_LIM |-> &bus_hiz_o;
   endproperty
   a_swoff: assert property (p_swoff) else $error("no Off after switch-off");
   property p_heat;
      overtemp_i [*3] |-> !bus_drive_dominant_o[0];
   endproperty
   a_heat: assert property (p_heat) else $error("driving while hot");
   property p_rx;
      nrm && $past(nrm, 2) && $past(bus_dominant_i[0]) == $past(bus_dominant_i[0], 2)
         |-> receive_output_o[0] == !$past(bus_dominant_i[0]);
   endproperty
   a_rx: assert property (p_rx) else $error("receive not following bus");
   c_tout: cover property (lo_ff == TO_LIM);
   c_off: cover property (uv_ff == SW_LIM);
   c_drv: cover property ($rose(bus_drive_dominant_o[0]));
endmodule
bind xcvr_mode_wake xcvr_mode_wake_asserts #(.TO_DOM_NS(TO_DOM_NS), .SWOFF_DET_NS(SWOFF_DET_NS))
   u_chk (.*);

// >>> test/xcvr_mode_wake_tb.sv
// Self-checking bench for the transceiver mode logic
`timescale 1ns/10ps
module xcvr_mode_wake_tb;
   import xcvr_mode_pkg::*;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, stbuv = 0, iouv = 1, ot = 0;
   logic        rel = 1, vsw = 0, pready, pslverr, err;
   logic [1:0]  txf = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0]  nrm = 2'h0, txl = 2'h0, bus = 2'h0, stb, stbd, tx, txd, rx, oe, drv, bias, hiz;
   int          n_mismatch = 0, tests_run = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("Error at %0t: timeout", $time);
         final_report();
      end
   end
   can_host_model host (.core_clk_i(clk), .want_normal_i(nrm), .tx_low_i(txl), .tx_float_i(txf),
      .standby_select_o(stb), .standby_driven_o(stbd), .transmit_input_o(tx),
      .transmit_driven_o(txd));
   xcvr_mode_wake #(.WAKE_WIN_NS(20000), .TO_DOM_NS(2000), .STARTUP_RX_NS(1000),
      .UV_DET_NS(500), .SWOFF_DET_NS(500)) dut (.core_clk_i(clk), .reset_i(rst),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .vcc_stb_uv_i(stbuv),
      .vcc_swoff_uv_i(vsw), .io_swoff_uv_i(iouv), .overtemp_i(ot), .temp_released_i(rel),
      .transmit_input_i(tx), .transmit_driven_i(txd), .standby_select_i(stb),
      .standby_driven_i(stbd), .receive_output_o(rx), .receive_output_oe_o(oe),
      .bus_dominant_i(bus), .bus_drive_dominant_o(drv), .bus_bias_gnd_o(bias), .bus_hiz_o(hiz));
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, then one idle edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic final_report();
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic test_regs();
      apb(0, CTRL_OFF, 0);
      chk(rd, 32'h2);
      apb(1, CTRL_OFF, 32'h3);
      apb(0, CTRL_OFF, 0);
      chk(rd, 32'h3);
      apb(1, CTRL_OFF, 32'h2);
      apb(0, 12'h008, 0);
      chk({rd[30:0], err}, 32'h1);
      iouv <= 0;
      wt(150);
      apb(0, STATUS_OFF, 0);
      chk({rd[9:8], rd[1:0]}, 32'h5);
      $display("registers and power-up done");
   endtask
   // Follow wake on channel 0, then latching wake on channel 1
   task automatic test_wake();
      bus <= 2'h1;
      wt(350);
      bus <= 2'h0;
      wt(350);
      chk(rx, 32'h3);
      bus <= 2'h1;
      wt(350);
      bus <= 2'h0;
      wt(50);
      chk(rx, 32'h3);
      wt(210);
      bus <= 2'h1;
      wt(150);
      chk(rx, 32'h2);
      apb(0, STATUS_OFF, 0);
      chk({rd[10], rd[2]}, 32'h1);
      apb(1, CTRL_OFF, 32'h3);
      bus <= 2'h3;
      wt(350);
      bus <= 2'h1;
      wt(350);
      bus <= 2'h3;
      wt(350);
      bus <= 2'h1;
      wt(300);
      chk(rx, 32'h0);
      apb(1, CTRL_OFF, 32'h2);
      $display("wake done");
   endtask
   // Normal mode, timeout, open pin and heat on channel 0
   task automatic test_normal();
      nrm <= 2'h1;
      wt(150);
      apb(0, STATUS_OFF, 0);
      chk({rd[9:8], rd[1:0]}, 32'h6);
      txl <= 2'h1;
      wt(5);
      chk({drv, rx}, 32'h6);
      wt(450);
      apb(0, STATUS_OFF, 0);
      chk({drv, rd[3]}, 32'h1);
      txl <= 2'h0;
      wt(5);
      txl <= 2'h1;
      wt(5);
      chk(drv, 32'h1);
      txf <= 2'h1;
      wt(5);
      chk(drv, 32'h0);
      txf <= 2'h0;
      ot <= 1;
      rel <= 0;
      wt(5);
      chk(drv, 32'h0);
      ot <= 0;
      rel <= 1;
      wt(5);
      chk(drv, 32'h0);
      txl <= 2'h0;
      wt(5);
      txl <= 2'h1;
      wt(5);
      chk(drv, 32'h1);
      $display("normal done");
   endtask
   // Supply loss, then Off governed by the main supply
   task automatic test_supply();
      stbuv <= 1;
      wt(150);
      chk({bias[0], drv[0], rx}, 32'hA);
      iouv <= 1;
      wt(150);
      chk({hiz, oe}, 32'hC);
      vsw <= 1;
      iouv <= 0;
      apb(1, CTRL_OFF, 32'h0);
      wt(150);
      chk(hiz, 32'h3);
      vsw <= 0;
      wt(150);
      chk({hiz, bias}, 32'h3);
      $display("supply done");
   endtask
   initial begin
      wt(10);
      rst <= 0;
      test_regs();
      test_wake();
      test_normal();
      test_supply();
      final_report();
   end
endmodule
